/* shared/eag_map.vh */
// constants for the effective address generator
`ifndef EAG_MAP_VH
`define EAG_MAP_VH

// operand modes presented by the sequencer
`define M_INHERENT 3'h0
`define M_IMMEDIATE 3'h1
`define M_EXTENDED 3'h2
`define M_DIRECT 3'h3
`define M_INDEXED 3'h4
`define M_BRANCH 3'h5
`define M_REGSEL 3'h6
`define M_STACK 3'h7

// sequencer states
`define ST_IDLE 2'h0
`define ST_FETCH 2'h1
`define ST_EVAL 2'h2

// what the last fetch burst was for
`define PH_OPND 2'h0
`define PH_POST 2'h1
`define PH_OFFS 2'h2
`define PH_IND 2'h3

// indexed postbyte fields
`define PB_DIRECT_FORM 7
`define PB_INDIRECT 4
`define PB_SEL_HI 6
`define PB_SEL_LO 5
`define PB_SIGN5 4
`define PB_EXT_INDIRECT 8'h9F

// low nibble of an indexed postbyte with bit 7 set
`define IX_INC1 4'h0
`define IX_INC2 4'h1
`define IX_DEC1 4'h2
`define IX_DEC2 4'h3
`define IX_NONE 4'h4
`define IX_ACC_B 4'h5
`define IX_ACC_A 4'h6
`define IX_OFF8 4'h8
`define IX_OFF16 4'h9
`define IX_ACC_D 4'hB
`define IX_IP8 4'hC
`define IX_IP16 4'hD
`define IX_EXT 4'hF

// pointer select field codes
`define PTR_FIRST 2'h0
`define PTR_SECOND 2'h1
`define PTR_USER 2'h2
`define PTR_HW 2'h3

// defined swap/copy register codes: 0..5 and 8..B
`define SW_LOW_MAX 4'h5
`define SW_HIGH_MIN 4'h8
`define SW_HIGH_MAX 4'hB

// fetch counts and step sizes
`define CNT_ONE 2'h1
`define CNT_TWO 2'h2
`define CNT_ZERO 2'h0
`define ZERO16 16'h0000
`define ZERO8 8'h00
`define ONE16 16'h0001
`define TWO16 16'h0002
`define ONES8 8'hFF
`define ONES11 11'h7FF
`define ZERO11 11'h000

`endif

/* verilog/effective_address_generator.v */
// operand addressing and postbyte decode for an 8-bit processor core
`timescale 1ns/10ps
`default_nettype none
`include "eag_map.vh"
//
// Summary of operation
// - inherent mode finishes at once, fetching no bytes.
// - immediate operand is the one or two bytes after the opcode.
// - swap/copy postbyte high nibble is source, low nibble destination.
// - swap/copy codes 0-5 and 8-B are defined; others flagged undefined.
// - push/pull postbyte bits 7..0 select ip, other stack, ..., flags.
// - extended address is the two bytes after the opcode.
// - direct address is page base high byte, next byte low.
// - constant offset added to pointer; pointer stays unchanged.
// - 5-bit offset from postbyte; 8/16-bit offsets follow the postbyte.
// - recognise no-offset, 5-bit, 8-bit and 16-bit direct postbytes.
// - indirect constant offsets; indirect 5-bit uses the 8-bit form.
// - accumulator offset a, b or pair added signed, nothing changed.
// - recognise increment 1/2 and decrement 1/2 postbytes.
// - indirect auto-step only for steps of two; others illegal.
// - auto-increment uses old pointer, then adds the step.
// - auto-decrement subtracts step first, uses new value.
// - ip-relative with 8 or 16-bit signed offset, direct or indirect.
// - indirection reads two bytes at base address as final address.
// - postbyte 9F: two bytes give address of the final address.
// - taken branch adds offset to ip past instruction; else next.
// - short branch uses one signed byte.
// - long branch uses two bytes as signed 16-bit offset.

module effective_address_generator (
	input wire ref_clk,
	input wire reset,
	input wire start,
	input wire [2:0] mode,
	input wire wide,
	input wire branch_taken,
	input wire [15:0] ip_in,
	input wire [15:0] index_first,
	input wire [15:0] index_second,
	input wire [15:0] stack_user,
	input wire [15:0] stack_hw,
	input wire [7:0] acc_a,
	input wire [7:0] acc_b,
	input wire [7:0] page_base_register,
	input wire [7:0] mem_data,
	input wire mem_ack,
	output reg mem_req_r,
	output reg [15:0] mem_addr_r,
	output reg busy_r,
	output reg done_r,
	output reg illegal_r,
	output reg [15:0] ea_r,
	output reg [15:0] operand_r,
	output reg [15:0] ip_out_r,
	output reg ptr_wr_r,
	output reg [1:0] ptr_sel_r,
	output reg [15:0] ptr_val_r,
	output reg [3:0] src_sel_r,
	output reg [3:0] dst_sel_r,
	output reg sel_ok_r,
	output reg [7:0] stack_mask_r
);

localparam S_IDLE = `ST_IDLE;
localparam S_FETCH = `ST_FETCH;
localparam S_EVAL = `ST_EVAL;

reg [1:0] state_r, phase_r, cnt_r;
reg [2:0] mode_r;
reg wide_r, taken_r, pend_r;
reg [15:0] ip_r, faddr_r, acc_r;
reg [7:0] pb_r;

// ==========================================================
// indexed decode
wire [7:0] pb;
wire [15:0] off8, off5, sext_a, sext_b;
reg [15:0] ptr, idx_ea, idx_step;
reg [1:0] idx_need;
reg idx_wr, idx_bad;

// postbyte is still in acc_r on the cycle right after its fetch
assign pb = (phase_r == `PH_POST) ? acc_r[7:0] : pb_r;
assign off8 = {{8{acc_r[7]}}, acc_r[7:0]};
assign off5 = {{11{pb[`PB_SIGN5]}}, pb[4:0]};
assign sext_a = {{8{acc_a[7]}}, acc_a};
assign sext_b = {{8{acc_b[7]}}, acc_b};

always @* begin
	case (pb[`PB_SEL_HI:`PB_SEL_LO])
	`PTR_FIRST: ptr = index_first;
	`PTR_SECOND: ptr = index_second;
	`PTR_USER: ptr = stack_user;
	default: ptr = stack_hw;
	endcase
end

always @* begin
	idx_ea = ptr;
	idx_step = ptr;
	idx_need = `CNT_ZERO;
	idx_wr = 1'b0;
	idx_bad = 1'b0;
	if (!pb[`PB_DIRECT_FORM]) begin
		idx_ea = ptr + off5;
	end else begin
		case (pb[3:0])
		`IX_INC1: begin
			idx_step = ptr + `ONE16;
			idx_wr = 1'b1;
			idx_bad = pb[`PB_INDIRECT];
		end
		`IX_INC2: begin
			idx_step = ptr + `TWO16;
			idx_wr = 1'b1;
		end
		`IX_DEC1: begin
			idx_step = ptr - `ONE16;
			idx_ea = ptr - `ONE16;
			idx_wr = 1'b1;
			idx_bad = pb[`PB_INDIRECT];
		end
		`IX_DEC2: begin
			idx_step = ptr - `TWO16;
			idx_ea = ptr - `TWO16;
			idx_wr = 1'b1;
		end
		`IX_NONE: idx_ea = ptr;
		`IX_ACC_A: idx_ea = ptr + sext_a;
		`IX_ACC_B: idx_ea = ptr + sext_b;
		`IX_ACC_D: idx_ea = ptr + {acc_a, acc_b};
		`IX_OFF8: begin
			// indirect 5-bit requests arrive here as the 8-bit form
			idx_need = `CNT_ONE;
			idx_ea = ptr + off8;
		end
		`IX_OFF16: begin
			idx_need = `CNT_TWO;
			idx_ea = ptr + acc_r;
		end
		`IX_IP8: begin
			// ip is already past the offset byte when this is used
			idx_need = `CNT_ONE;
			idx_ea = faddr_r + off8;
		end
		`IX_IP16: begin
			idx_need = `CNT_TWO;
			idx_ea = faddr_r + acc_r;
		end
		`IX_EXT: begin
			idx_need = `CNT_TWO;
			idx_ea = acc_r;
			idx_bad = (pb != `PB_EXT_INDIRECT);
		end
		default: idx_bad = 1'b1;
		endcase
	end
end

// ==========================================================
// sequencer
always @(posedge ref_clk or posedge reset) begin
	if (reset) begin
		state_r <= S_IDLE;
		phase_r <= `PH_OPND;
		mode_r <= `M_INHERENT;
		wide_r <= 1'b0;
		taken_r <= 1'b0;
		ip_r <= `ZERO16;
		faddr_r <= `ZERO16;
		acc_r <= `ZERO16;
		cnt_r <= `CNT_ZERO;
		pb_r <= `ZERO8;
		pend_r <= 1'b0;
		mem_req_r <= 1'b0;
		mem_addr_r <= `ZERO16;
		busy_r <= 1'b0;
		done_r <= 1'b0;
		illegal_r <= 1'b0;
		ea_r <= `ZERO16;
		operand_r <= `ZERO16;
		ip_out_r <= `ZERO16;
		ptr_wr_r <= 1'b0;
		ptr_sel_r <= `PTR_FIRST;
		ptr_val_r <= `ZERO16;
		src_sel_r <= 4'h0;
		dst_sel_r <= 4'h0;
		sel_ok_r <= 1'b0;
		stack_mask_r <= `ZERO8;
	end else begin
		done_r <= 1'b0;
		ptr_wr_r <= 1'b0;
		case (state_r)
		S_IDLE: begin
			if (start) begin
				mode_r <= mode;
				wide_r <= wide;
				taken_r <= branch_taken;
				ip_r <= ip_in;
				faddr_r <= ip_in;
				acc_r <= `ZERO16;
				pend_r <= 1'b0;
				illegal_r <= 1'b0;
				state_r <= S_FETCH;
				busy_r <= 1'b1;
				phase_r <= `PH_OPND;
				cnt_r <= `CNT_ONE;
				case (mode)
				`M_INHERENT: begin
					state_r <= S_IDLE;
					busy_r <= 1'b0;
					done_r <= 1'b1;
					ea_r <= `ZERO16;
					ip_out_r <= ip_in;
				end
				`M_IMMEDIATE, `M_BRANCH:
					cnt_r <= wide ? `CNT_TWO : `CNT_ONE;
				`M_EXTENDED: cnt_r <= `CNT_TWO;
				`M_DIRECT: cnt_r <= `CNT_ONE;
				default: phase_r <= `PH_POST;
				endcase
			end
		end
		S_FETCH: begin
			if (!mem_req_r) begin
				mem_req_r <= 1'b1;
				mem_addr_r <= faddr_r;
			end else if (mem_ack) begin
				// first byte lands high: high byte at lower address
				mem_req_r <= 1'b0;
				acc_r <= {acc_r[7:0], mem_data};
				faddr_r <= faddr_r + `ONE16;
				cnt_r <= cnt_r - `CNT_ONE;
				if (cnt_r == `CNT_ONE)
					state_r <= S_EVAL;
			end
		end
		S_EVAL: begin
			state_r <= S_IDLE;
			busy_r <= 1'b0;
			done_r <= 1'b1;
			ip_r <= faddr_r;
			ip_out_r <= faddr_r;
			case (phase_r)
			`PH_OPND: begin
				case (mode_r)
				`M_IMMEDIATE: begin
					ea_r <= ip_r;
					operand_r <= wide_r ? acc_r : {`ZERO8, acc_r[7:0]};
				end
				`M_EXTENDED: ea_r <= acc_r;
				`M_DIRECT: ea_r <= {page_base_register, acc_r[7:0]};
				default: begin
					if (taken_r) begin
						ea_r <= faddr_r + (wide_r ? acc_r : off8);
						ip_out_r <= faddr_r + (wide_r ? acc_r : off8);
					end else begin
						ea_r <= faddr_r;
					end
				end
				endcase
			end
			`PH_POST: begin
				pb_r <= acc_r[7:0];
				case (mode_r)
				`M_REGSEL: begin
					src_sel_r <= acc_r[7:4];
					dst_sel_r <= acc_r[3:0];
					sel_ok_r <= ((acc_r[7:4] <= `SW_LOW_MAX) ||
						(acc_r[7:4] >= `SW_HIGH_MIN &&
						acc_r[7:4] <= `SW_HIGH_MAX)) &&
						((acc_r[3:0] <= `SW_LOW_MAX) ||
						(acc_r[3:0] >= `SW_HIGH_MIN &&
						acc_r[3:0] <= `SW_HIGH_MAX));
				end
				`M_STACK: stack_mask_r <= acc_r[7:0];
				default: begin
					// pointer write is held back until the whole access ends
					pend_r <= idx_wr;
					ptr_sel_r <= pb[`PB_SEL_HI:`PB_SEL_LO];
					ptr_val_r <= idx_step;
					if (idx_bad) begin
						illegal_r <= 1'b1;
						ea_r <= `ZERO16;
					end else if (idx_need != `CNT_ZERO) begin
						cnt_r <= idx_need;
						phase_r <= `PH_OFFS;
						state_r <= S_FETCH;
						busy_r <= 1'b1;
						done_r <= 1'b0;
					end else if (pb[`PB_DIRECT_FORM] && pb[`PB_INDIRECT]) begin
						faddr_r <= idx_ea;
						cnt_r <= `CNT_TWO;
						phase_r <= `PH_IND;
						state_r <= S_FETCH;
						busy_r <= 1'b1;
						done_r <= 1'b0;
					end else begin
						ea_r <= idx_ea;
						ptr_wr_r <= idx_wr;
					end
				end
				endcase
			end
			`PH_OFFS: begin
				if (pb[`PB_INDIRECT]) begin
					faddr_r <= idx_ea;
					cnt_r <= `CNT_TWO;
					phase_r <= `PH_IND;
					state_r <= S_FETCH;
					busy_r <= 1'b1;
					done_r <= 1'b0;
				end else begin
					ea_r <= idx_ea;
					ptr_wr_r <= pend_r;
				end
			end
			default: begin
				ea_r <= acc_r;
				ip_out_r <= ip_r;
				ptr_wr_r <= pend_r;
			end
			endcase
		end
		default: state_r <= S_IDLE;
		endcase
	end
end

endmodule
`default_nettype wire

/* verification/eag_mem.sv */
// memory partner answering the generator's byte reads
`timescale 1ns/10ps
`default_nettype none
module eag_mem (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic slow,
	input wire logic mem_req_r,
	input wire logic [15:0] mem_addr_r,
	output logic [7:0] mem_data,
	output logic mem_ack
);
	logic [7:0] mem [0:65535];
	logic [1:0] wait_r;
	initial begin
		for (int a = 0; a < 65536; a++) mem[a] = a[7:0] ^ a[15:8];
	end
	// ==========
	// answer
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			mem_ack <= 1'b0;
			mem_data <= 8'h00;
			wait_r <= 2'h0;
		end else if (mem_req_r && !mem_ack && wait_r == {slow, slow}) begin
			mem_ack <= 1'b1;
			mem_data <= mem[mem_addr_r];
			wait_r <= 2'h0;
		end else begin
			// data is inverted every cycle without an ack, so the stale byte reappears every other cycle
			mem_ack <= 1'b0;
			mem_data <= ~mem_data;
			wait_r <= (mem_req_r && !mem_ack) ? wait_r + 2'h1 : 2'h0;
		end
	end
endmodule
`default_nettype wire

/* verification/effective_address_generator_checker.sv */
// port assertions for the effective address generator
`timescale 1ns/10ps
`default_nettype none
`include "eag_map.vh"
module effective_address_generator_checker (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic start,
	input wire logic [2:0] mode,
	input wire logic [15:0] ip_in,
	input wire logic mem_ack,
	input wire logic mem_req_r,
	input wire logic [15:0] mem_addr_r,
	input wire logic busy_r,
	input wire logic done_r,
	input wire logic illegal_r,
	input wire logic [15:0] ea_r,
	input wire logic ptr_wr_r
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_take;
		start && !busy_r;
	endsequence
	sequence s_ack;
		mem_req_r && mem_ack;
	endsequence
	// ==========
	// properties
	AST_INH: assert property (
		s_take ##0 mode == `M_INHERENT |=> done_r && ea_r == 16'h0000)
		else $error("inherent op not done at once");
	AST_FETCH: assert property (
		s_take ##0 (mode == `M_IMMEDIATE || mode == `M_EXTENDED ||
		mode == `M_DIRECT) |=> ##1 (mem_req_r &&
		mem_addr_r == $past(ip_in, 2)))
		else $error("first fetch not at ip");
	AST_BUSY: assert property (
		s_take ##0 mode != `M_INHERENT |=> busy_r && !done_r)
		else $error("fetching op not busy");
	AST_HOLD: assert property (
		mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r))
		else $error("request moved before ack");
	AST_DROP: assert property (
		s_ack |=> !mem_req_r)
		else $error("request kept after ack");
	AST_IDLE: assert property (
		!busy_r |-> !mem_req_r)
		else $error("request while idle");
	AST_PTR: assert property (
		ptr_wr_r |-> done_r && !illegal_r)
		else $error("pointer write outside done");
	AST_ILL: assert property (
		done_r && illegal_r |-> !ptr_wr_r && ea_r == 16'h0000)
		else $error("illegal postbyte had effects");
	AST_PULSE: assert property (
		done_r && !start |=> !done_r)
		else $error("done longer than a cycle");
endmodule
bind effective_address_generator effective_address_generator_checker i_chk (
	.ref_clk, .reset, .start, .mode, .ip_in, .mem_ack, .mem_req_r,
	.mem_addr_r, .busy_r, .done_r, .illegal_r, .ea_r, .ptr_wr_r);
`default_nettype wire

/* verification/effective_address_generator_bench.sv */
// self-checking bench for the effective address generator
`timescale 1ns/10ps
`default_nettype none
`include "eag_map.vh"
module effective_address_generator_bench;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	logic wide = 1'b0;
	logic branch_taken = 1'b0;
	logic slow = 1'b0;
	logic [2:0] mode = 3'h0;
	logic [15:0] ip_in = 16'h0000;
	logic [15:0] index_first = 16'h1000;
	logic [15:0] index_second = 16'h2000;
	logic [15:0] stack_user = 16'h3000;
	logic [15:0] stack_hw = 16'h4000;
	logic [7:0] acc_a = 8'h00;
	logic [7:0] acc_b = 8'h00;
	logic [7:0] page_base_register = 8'h00;
	wire [7:0] mem_data;
	wire mem_ack, mem_req_r, busy_r, done_r, illegal_r, ptr_wr_r, sel_ok_r;
	wire [15:0] mem_addr_r, ea_r, operand_r, ip_out_r, ptr_val_r;
	wire [1:0] ptr_sel_r;
	wire [3:0] src_sel_r, dst_sel_r;
	wire [7:0] stack_mask_r;
	int fail_count = 0;
	int n_compared = 0;
	effective_address_generator i_effective_address_generator (.ref_clk,
		.reset, .start, .mode, .wide, .branch_taken, .ip_in, .index_first,
		.index_second, .stack_user, .stack_hw, .acc_a, .acc_b,
		.page_base_register, .mem_data, .mem_ack, .mem_req_r, .mem_addr_r,
		.busy_r, .done_r, .illegal_r, .ea_r, .operand_r, .ip_out_r,
		.ptr_wr_r, .ptr_sel_r, .ptr_val_r, .src_sel_r, .dst_sel_r,
		.sel_ok_r, .stack_mask_r);
	eag_mem i_eag_mem (.ref_clk, .reset, .slow, .mem_req_r, .mem_addr_r,
		.mem_data, .mem_ack);
	// ==========
	// helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic run(input logic [2:0] m, input logic w, input logic t,
		input logic [15:0] ip);
		int n;
		@(negedge ref_clk);
		mode = m;
		wide = w;
		branch_taken = t;
		ip_in = ip;
		start = 1'b1;
		@(negedge ref_clk);
		start = 1'b0;
		for (n = 0; n < 100 && done_r !== 1'b1; n++) @(negedge ref_clk);
		chk(done_r, 1'b1);
	endtask
	task automatic ix(input logic [7:0] pb, input logic [15:0] ea,
		input logic [15:0] of = 16'h0000, input logic [15:0] pv = 16'h0000);
		i_eag_mem.mem[16'h0100] = pb;
		i_eag_mem.mem[16'h0101] = of[15:8];
		i_eag_mem.mem[16'h0102] = of[7:0];
		run(`M_INDEXED, 1'b0, 1'b0, 16'h0100);
		chk(ea_r, ea);
		chk(ptr_wr_r, pv != 16'h0000);
		if (pv != 16'h0000) begin
			chk(ptr_val_r, pv);
			chk(ptr_sel_r, pb[6:5]);
		end
	endtask
	// ==========
	// scenarios
	task automatic t_plain;
		run(`M_INHERENT, 1'b0, 1'b0, 16'h1234);
		chk(ip_out_r, 16'h1234);
		run(`M_IMMEDIATE, 1'b0, 1'b0, 16'h1234);
		chk(operand_r, 16'h0026);
		run(`M_IMMEDIATE, 1'b1, 1'b0, 16'h1234);
		chk(operand_r, 16'h2627);
		chk(ip_out_r, 16'h1236);
		run(`M_EXTENDED, 1'b0, 1'b0, 16'h12FF);
		chk(ea_r, 16'hED13);
		page_base_register = 8'h7C;
		run(`M_DIRECT, 1'b0, 1'b0, 16'h3010);
		chk(ea_r, 16'h7C20);
		$display("plain modes done");
	endtask
	task automatic t_indexed;
		acc_a = 8'hF0;
		acc_b = 8'h05;
		i_eag_mem.mem[16'h1000] = 8'h12;
		i_eag_mem.mem[16'h1001] = 8'h34;
		ix(8'h84, 16'h1000);
		ix(8'h2F, 16'h200F);
		ix(8'h70, 16'h3FF0);
		ix(8'hC8, 16'h2F80, 16'h8000);
		ix(8'h89, 16'h0000, 16'hF000);
		ix(8'hA6, 16'h1FF0);
		ix(8'hA5, 16'h2005);
		ix(8'hAB, 16'h1005);
		ix(8'h80, 16'h1000, 16'h0000, 16'h1001);
		ix(8'hE1, 16'h4000, 16'h0000, 16'h4002);
		ix(8'hC2, 16'h2FFF, 16'h0000, 16'h2FFF);
		ix(8'hA3, 16'h1FFE, 16'h0000, 16'h1FFE);
		slow = 1'b1;
		ix(8'h8C, 16'h0112, 16'h1000);
		ix(8'h8D, 16'h0203, 16'h0100);
		ix(8'h94, 16'h1234);
		ix(8'h9F, 16'h1234, 16'h1000);
		ix(8'hB1, 16'h2021, 16'h0000, 16'h2002);
		ix(8'hD8, 16'hD030, 16'hFF00);
		ix(8'h90, 16'h0000);
		chk(illegal_r, 1'b1);
		$display("indexed modes done");
	endtask
	task automatic t_branch;
		i_eag_mem.mem[16'h0200] = 8'h80;
		i_eag_mem.mem[16'h0201] = 8'h00;
		run(`M_BRANCH, 1'b0, 1'b1, 16'h0200);
		chk(ip_out_r, 16'h0181);
		run(`M_BRANCH, 1'b0, 1'b0, 16'h0200);
		chk(ip_out_r, 16'h0201);
		run(`M_BRANCH, 1'b1, 1'b1, 16'h0200);
		chk(ip_out_r, 16'h8202);
		$display("branch done");
	endtask
	task automatic t_select;
		i_eag_mem.mem[16'h0300] = 8'h5B;
		i_eag_mem.mem[16'h0301] = 8'h6C;
		i_eag_mem.mem[16'h0302] = 8'hA5;
		run(`M_REGSEL, 1'b0, 1'b0, 16'h0300);
		chk({src_sel_r, dst_sel_r, sel_ok_r}, 9'h0B7);
		run(`M_REGSEL, 1'b0, 1'b0, 16'h0301);
		chk(sel_ok_r, 1'b0);
		run(`M_STACK, 1'b0, 1'b0, 16'h0302);
		chk(stack_mask_r, 8'hA5);
		$display("select done");
	endtask
	task automatic t_reset;
		// reset after the op has finished must clear results left by the last op
		run(`M_STACK, 1'b0, 1'b0, 16'h0302);
		@(negedge ref_clk);
		reset = 1'b1;
		@(negedge ref_clk);
		chk({done_r, busy_r, mem_req_r, illegal_r, sel_ok_r, stack_mask_r},
			16'h0000);
		chk(ip_out_r, 16'h0000);
		chk(ea_r, 16'h0000);
		reset = 1'b0;
		run(`M_INHERENT, 1'b0, 1'b0, 16'h0042);
		chk(ip_out_r, 16'h0042);
		$display("reset done");
	endtask
	task automatic complete_run;
		$display("compared %0d, failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ==========
	// sequence
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		// whole run is a few hundred cycles
		#200000;
		fail_count++;
		complete_run();
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		t_plain();
		t_indexed();
		t_branch();
		t_select();
		t_reset();
		complete_run();
	end
endmodule
`default_nettype wire
